// >>> core/rx_writer_pkg.sv
package rx_writer_pkg;
	// ------------------------------------------------
	// frame decode
	// ------------------------------------------------
	localparam logic [7:0]  FIS_TYPE_DATA  = 8'h46;
	localparam int          FIS_TYPE_LSB   = 0;
	// ------------------------------------------------
	// burst geometry: 16 beats of 256 bits
	// ------------------------------------------------
	localparam int          LINK_W         = 32;
	localparam int          BEAT_W         = 256;
	localparam int          WORDS_PER_BEAT = BEAT_W / LINK_W;
	localparam int          BURST_BEATS    = 16;
	localparam int          BURST_WORDS    = BURST_BEATS * WORDS_PER_BEAT;
	localparam int          FILL_W         = $clog2(BURST_WORDS);
	localparam logic [31:0] BURST_BYTES    = 32'h0000_0200;
	localparam logic [7:0]  AXI_LEN        = 8'h0F;
	localparam logic [2:0]  AXI_SIZE       = 3'h5;
	localparam logic [1:0]  AXI_INCR       = 2'h1;
	// ------------------------------------------------
	// status and clear word layout
	// ------------------------------------------------
	localparam int          STAT_TYPE_BIT  = 31;
	localparam int          CNT_W          = 24;
	localparam int          CLR_IRQ_BIT    = 30;
	localparam int          CLR_TYPE_BIT   = 29;
	localparam logic [CNT_W-1:0] CNT_RESET = 24'h00_0000;
	// ------------------------------------------------
	// state machines
	// ------------------------------------------------
	typedef enum logic [3:0] {
		I_HDR   = 4'h1,
		I_BODY  = 4'h2,
		I_PAD   = 4'h4,
		I_DRAIN = 4'h8
	} ingest_state_t;
	typedef enum logic [3:0] {
		W_IDLE = 4'h1,
		W_ADDR = 4'h2,
		W_DATA = 4'h4,
		W_RESP = 4'h8
	} write_state_t;
endpackage

// >>> core/fis_type_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module fis_type_decoder
	import rx_writer_pkg::*;
(
	// first word of a frame
	input  wire logic [LINK_W-1:0] hdr_word,
	// decode result
	output logic                   is_data
);
	// -----------------------------------------------
	// type byte sits in the low lane of word 0
	// -----------------------------------------------
	always_comb begin
		is_data = (hdr_word[FIS_TYPE_LSB +: 8] == FIS_TYPE_DATA);
	end
endmodule // fis_type_decoder
`default_nettype wire

// >>> core/asym_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module asym_fifo #(
	parameter int IN_W  = 32,
	parameter int RATIO = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  srst,
	// narrow fill side
	input  wire logic                  in_valid,
	output logic                       in_ready,
	input  wire logic [IN_W-1:0]       in_data,
	// wide drain side
	output logic                       out_valid,
	input  wire logic                  out_ready,
	output logic [IN_W*RATIO-1:0]      out_data,
	output logic [$clog2(DEPTH):0]     out_count,
	output logic                       empty
);
	localparam int SLOTS = DEPTH * RATIO;
	localparam int PW    = $clog2(SLOTS);
	localparam int CW    = PW + 1;

	logic [IN_W-1:0] mem_reg [SLOTS];
	logic [PW-1:0]   wr_ptr_reg, wr_ptr_next;
	logic [PW-1:0]   rd_ptr_reg, rd_ptr_next;
	logic [CW-1:0]   cnt_reg, cnt_next;
	logic            push, pop;

	// -----------------------------------------------
	// flags: counted in narrow words, read in wide
	// -----------------------------------------------
	always_comb begin
		in_ready  = (cnt_reg != CW'(SLOTS));
		out_valid = (cnt_reg >= CW'(RATIO));
		empty     = (cnt_reg == '0);
		out_count = cnt_reg[CW-1 -: $clog2(DEPTH)+1];
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		for (int i = 0; i < RATIO; i++) begin
			out_data[i*IN_W +: IN_W] = mem_reg[rd_ptr_reg + PW'(i)];
		end
	end

	// -----------------------------------------------
	// pointer and count next values
	// -----------------------------------------------
	always_comb begin
		wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
		rd_ptr_next = pop ? rd_ptr_reg + PW'(RATIO) : rd_ptr_reg;
		cnt_next    = cnt_reg + CW'(push) - (pop ? CW'(RATIO) : '0);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			cnt_reg    <= cnt_next;
		end
	end

	// storage has no reset; flags guard every read
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	// -----------------------------------------------
	// checks
	// -----------------------------------------------
	// push is gated by in_ready, so the count can never pass capacity
	fill_bound_a: assert property (@(posedge core_clk) disable iff (srst)
		cnt_reg <= CW'(SLOTS))
		else $error("buffer count beyond its capacity");
endmodule // asym_fifo
`default_nettype wire

// >>> core/rx_frame_writer.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - decode frame type, drive destination select
// - data frames to disk image, others apart
// - drop header word of data frames
// - bursts are sixteen beats of 256 bits
// - pad frame tail with dummy words
// - request address only when burst buffered
// - return to idle after each burst
// - interrupt on frame, expose word count
// - status bit 31 type, 23:0 count
// - clear bits 30 and 29 clear flags
// - buffer takes 32 bits, gives 256
module rx_frame_writer
	import rx_writer_pkg::*;
#(
	parameter int FIFO_DEPTH = BURST_BEATS
) (
	// clock and reset
	input  wire logic                core_clk,
	input  wire logic                srst,
	// link core receive stream
	input  wire logic [LINK_W-1:0]   rx_data,
	input  wire logic                rx_valid,
	input  wire logic                rx_sof,
	input  wire logic                rx_eof,
	output logic                     rx_ready,
	// software control
	input  wire logic [31:0]         disk_image_region_base,
	input  wire logic [31:0]         other_frame_region_base,
	input  wire logic                start_transfer,
	input  wire logic                int_clear_wr,
	input  wire logic [31:0]         int_clear_data,
	// software status
	output logic                     frame_irq,
	output logic [31:0]              status_word,
	output logic                     rx_destination_select,
	// axi4 write address
	output logic [31:0]              awaddr,
	output logic [7:0]               awlen,
	output logic [2:0]               awsize,
	output logic [1:0]               awburst,
	output logic                     awvalid,
	input  wire logic                awready,
	// axi4 write data
	output logic [BEAT_W-1:0]        wdata,
	output logic [BEAT_W/8-1:0]      wstrb,
	output logic                     wlast,
	output logic                     wvalid,
	input  wire logic                wready,
	// axi4 write response
	input  wire logic [1:0]          bresp,
	input  wire logic                bvalid,
	output logic                     bready
);
	localparam int OCW = $clog2(FIFO_DEPTH) + 1;
	ingest_state_t       ing_reg, ing_next;
	write_state_t        wr_reg, wr_next;
	logic [FILL_W-1:0]   fill_reg, fill_next;
	logic [CNT_W-1:0]    cnt_reg, cnt_next;
	logic                mode_reg, mode_next;
	logic                irq_reg, irq_next;
	logic                type_reg, type_next;
	logic [31:0]         addr_data_reg, addr_data_next;
	logic [31:0]         addr_other_reg, addr_other_next;
	logic [31:0]         awaddr_reg, awaddr_next;
	logic [3:0]          beat_reg, beat_next;
	logic                is_data, accept, push, frame_done;
	logic                fifo_in_ready, fifo_out_valid, fifo_empty;
	logic                pop, burst_done, clr_irq, clr_type;
	logic [LINK_W-1:0]   fifo_din;
	logic [OCW-1:0]      out_count;

	// -----------------------------------------------
	// frame type decode and buffer
	// -----------------------------------------------
	fis_type_decoder u_dec (
		.hdr_word (rx_data),
		.is_data  (is_data)
	);

	asym_fifo #(
		.IN_W  (LINK_W),
		.RATIO (WORDS_PER_BEAT),
		.DEPTH (FIFO_DEPTH)
	) ddr_write_buffer_fifo (
		.core_clk  (core_clk),
		.srst      (srst),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_din),
		.out_valid (fifo_out_valid),
		.out_ready (pop),
		.out_data  (wdata),
		.out_count (out_count),
		.empty     (fifo_empty)
	);

	// -----------------------------------------------
	// ingest: strip, push, pad, then wait for drain
	// -----------------------------------------------
	always_comb begin
		rx_ready   = fifo_in_ready && (ing_reg == I_HDR || ing_reg == I_BODY);
		accept     = rx_valid && rx_ready;
		push       = 1'b0;
		fifo_din   = rx_data;
		frame_done = 1'b0;
		ing_next   = ing_reg;
		mode_next  = mode_reg;
		unique case (ing_reg)
			I_HDR: begin
				if (accept) begin
					mode_next = !is_data;
					push      = !is_data;
					ing_next  = I_BODY;
				end
			end
			I_BODY: begin
				push = accept;
			end
			I_PAD: begin
				push     = fifo_in_ready;
				fifo_din = '0;
			end
			I_DRAIN: begin
				// one frame at a time keeps the region choice stable
				if (fifo_empty && wr_reg == W_IDLE) begin
					frame_done = 1'b1;
					ing_next   = I_HDR;
				end
			end
		endcase
		fill_next = push ? fill_reg + 1'b1 : fill_reg;
		if (accept && rx_eof) begin
			ing_next = (fill_next != '0) ? I_PAD : I_DRAIN;
		end
		if (ing_reg == I_PAD && push && fill_next == '0) begin
			ing_next = I_DRAIN;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ing_reg  <= I_HDR;
			fill_reg <= '0;
			mode_reg <= 1'b0;
		end else begin
			ing_reg  <= ing_next;
			fill_reg <= fill_next;
			mode_reg <= mode_next;
		end
	end

	// -----------------------------------------------
	// count, interrupt and type flag; set beats clear
	// -----------------------------------------------
	always_comb begin
		clr_irq   = int_clear_wr && int_clear_data[CLR_IRQ_BIT];
		clr_type  = int_clear_wr && int_clear_data[CLR_TYPE_BIT];
		cnt_next  = start_transfer ? CNT_RESET : cnt_reg;
		if (push && ing_reg != I_PAD) begin
			cnt_next = cnt_next + 1'b1;
		end
		irq_next  = frame_done ? 1'b1 : (clr_irq ? 1'b0 : irq_reg);
		type_next = frame_done ? mode_reg
			: (clr_type ? 1'b0 : type_reg);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cnt_reg  <= CNT_RESET;
			irq_reg  <= 1'b0;
			type_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			irq_reg  <= irq_next;
			type_reg <= type_next;
		end
	end

	// status word, unused bits read as zero
	always_comb begin
		frame_irq             = irq_reg;
		rx_destination_select = mode_reg;
		status_word           = '0;
		status_word[STAT_TYPE_BIT] = type_reg;
		status_word[CNT_W-1:0]     = cnt_reg;
	end

	// -----------------------------------------------
	// address generator, one pointer per region
	// -----------------------------------------------
	always_comb begin
		addr_data_next  = addr_data_reg;
		addr_other_next = addr_other_reg;
		if (start_transfer) begin
			addr_data_next  = disk_image_region_base;
			addr_other_next = other_frame_region_base;
		end else if (burst_done) begin
			if (mode_reg) begin
				addr_other_next = addr_other_reg + BURST_BYTES;
			end else begin
				addr_data_next  = addr_data_reg + BURST_BYTES;
			end
		end
	end

	// no alignment fixing: bases arrive 512-byte aligned
	always_ff @(posedge core_clk) begin
		if (srst) begin
			addr_data_reg  <= '0;
			addr_other_reg <= '0;
		end else begin
			addr_data_reg  <= addr_data_next;
			addr_other_reg <= addr_other_next;
		end
	end

	// -----------------------------------------------
	// write side: one fixed burst per trip from idle
	// -----------------------------------------------
	always_comb begin
		wr_next     = wr_reg;
		awaddr_next = awaddr_reg;
		beat_next   = beat_reg;
		awvalid     = (wr_reg == W_ADDR);
		wvalid      = (wr_reg == W_DATA) && fifo_out_valid;
		pop         = wvalid && wready;
		wlast       = (beat_reg == 4'(BURST_BEATS - 1));
		bready      = (wr_reg == W_RESP);
		burst_done  = bvalid && bready;
		unique case (wr_reg)
			W_IDLE: begin
				beat_next = '0;
				if (out_count >= OCW'(BURST_BEATS)) begin
					awaddr_next = mode_reg ? addr_other_reg
						: addr_data_reg;
					wr_next     = W_ADDR;
				end
			end
			W_ADDR: begin
				if (awready) begin
					wr_next = W_DATA;
				end
			end
			W_DATA: begin
				if (pop) begin
					beat_next = beat_reg + 1'b1;
					if (wlast) begin
						wr_next = W_RESP;
					end
				end
			end
			W_RESP: begin
				if (bvalid) begin
					wr_next = W_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			wr_reg     <= W_IDLE;
			awaddr_reg <= '0;
			beat_reg   <= '0;
		end else begin
			wr_reg     <= wr_next;
			awaddr_reg <= awaddr_next;
			beat_reg   <= beat_next;
		end
	end

	// fixed burst shape; error responses are not retried
	assign awaddr  = awaddr_reg;
	assign awlen   = AXI_LEN;
	assign awsize  = AXI_SIZE;
	assign awburst = AXI_INCR;
	assign wstrb   = '1;

	// -----------------------------------------------
	// checks
	// -----------------------------------------------
	logic [4:0] beats_seen_reg;
	always_ff @(posedge core_clk) begin
		if (srst || (awvalid && awready)) begin
			beats_seen_reg <= '0;
		end else if (pop) begin
			beats_seen_reg <= beats_seen_reg + 1'b1;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	sequence frame_closes;
		ing_reg == I_DRAIN && fifo_empty && wr_reg == W_IDLE;
	endsequence
	sequence burst_issued;
		awvalid && awready;
	endsequence
	burst_beats_a: assert property (burst_done |->
		beats_seen_reg == 5'(BURST_BEATS))
		else $error("burst did not carry sixteen beats");
	aw_when_full_a: assert property ($rose(awvalid) |->
		$past(out_count) >= OCW'(BURST_BEATS))
		else $error("address issued without a full burst");
	idle_after_a: assert property (burst_done |=>
		wr_reg == W_IDLE && !awvalid)
		else $error("writer not idle after response");
	hdr_dropped_a: assert property (accept && ing_reg == I_HDR
		&& is_data |-> !push)
		else $error("data frame header reached buffer");
	tail_aligned_a: assert property ($rose(ing_reg == I_DRAIN) |->
		fill_reg == '0)
		else $error("frame tail not padded to burst");
	region_pick_a: assert property (burst_issued |-> awaddr ==
		(rx_destination_select ? addr_other_reg : addr_data_reg))
		else $error("burst aimed at wrong region");
	addr_step_a: assert property (burst_done && !start_transfer
		&& !mode_reg |=> addr_data_reg ==
		$past(addr_data_reg) + BURST_BYTES)
		else $error("address did not advance by one burst");
	type_select_a: assert property (accept && ing_reg == I_HDR |=>
		rx_destination_select == !$past(is_data))
		else $error("destination select does not follow type");
	irq_raise_a: assert property (frame_closes |=>
		frame_irq && status_word[STAT_TYPE_BIT] == $past(mode_reg))
		else $error("frame end did not raise interrupt");
	irq_clear_a: assert property (clr_irq && !frame_done |=>
		!frame_irq)
		else $error("interrupt clear ignored");
	count_clear_a: assert property (start_transfer && !push |=>
		status_word[CNT_W-1:0] == '0)
		else $error("count not cleared at start");
endmodule // rx_frame_writer
`default_nettype wire

// >>> tb/ddr_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// memory controller write side, random stalls
// ------------------------------------------------
module ddr_slave_model (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       srst,
	// write channels from the block
	input  wire logic       awvalid,
	input  wire logic       wvalid,
	input  wire logic       wlast,
	input  wire logic       bready,
	// handshakes back
	output var logic        awready,
	output var logic        wready,
	output var logic        bvalid,
	output var logic [1:0]  bresp
);
	int   pending;
	logic flip = 1'b0;
	// ready lines wander so slow and prompt answers both occur
	always @(posedge core_clk) begin
		flip <= ~flip;
		if (srst) begin
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			pending = 0;
		end else begin
			awready <= ($urandom % 2) == 1;
			wready  <= ($urandom % 4) != 0;
			// response only after the last beat was taken
			if (wvalid && wready && wlast)
				pending = pending + 1;
			if (bvalid && bready)
				bvalid <= 1'b0;
			else if (!bvalid && pending > 0 && ($urandom % 2) == 1) begin
				bvalid  <= 1'b1;
				pending = pending - 1;
			end
		end
	end
	// response code is meaningless outside bvalid, so keep it moving
	assign bresp = bvalid ? 2'h0 : {flip, ~flip};
endmodule // ddr_slave_model
`default_nettype wire

// >>> tb/test_rx_frame_writer.sv
`timescale 1ns/1ns
`default_nettype none
module test_rx_frame_writer;
	import rx_writer_pkg::*;
	logic core_clk, srst, rx_valid, rx_sof, rx_eof, rx_ready, start_transfer;
	logic int_clear_wr, frame_irq, rx_destination_select;
	logic awvalid, awready, wlast, wvalid, wready, bvalid, bready;
	logic [31:0] rx_data, disk_image_region_base, other_frame_region_base;
	logic [31:0] int_clear_data, status_word, awaddr;
	logic [7:0] awlen;
	logic [2:0] awsize;
	logic [1:0] awburst, bresp;
	logic [BEAT_W-1:0] wdata;
	logic [BEAT_W/8-1:0] wstrb;
	int fails, cmp_count, cycles, beat_n;
	logic [BEAT_W-1:0] exp_beat[$];
	logic [31:0] exp_addr[$];
	rx_frame_writer i_rx_frame_writer (.core_clk(core_clk), .srst(srst),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_sof(rx_sof),
		.rx_eof(rx_eof), .rx_ready(rx_ready),
		.disk_image_region_base(disk_image_region_base),
		.other_frame_region_base(other_frame_region_base),
		.start_transfer(start_transfer), .int_clear_wr(int_clear_wr),
		.int_clear_data(int_clear_data), .frame_irq(frame_irq),
		.status_word(status_word),
		.rx_destination_select(rx_destination_select),
		.awaddr(awaddr), .awlen(awlen), .awsize(awsize), .awburst(awburst),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wlast(wlast), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready));
	ddr_slave_model i_ddr_slave_model (.core_clk(core_clk), .srst(srst),
		.awvalid(awvalid), .wvalid(wvalid), .wlast(wlast), .bready(bready),
		.awready(awready), .wready(wready), .bvalid(bvalid), .bresp(bresp));
	// ------------------------------------------------
	// clock, timeout and reporting
	// ------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	task automatic final_report();
		if (fails == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(logic [255:0] seen, logic [255:0] exp, string what);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: %s seen %0h want %0h", $time, what,
				seen, exp);
		end
	endtask
	// bench hangs are cut short well past the longest frame
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			final_report();
		end
	end
	// ------------------------------------------------
	// write channel monitor against the model queues
	// ------------------------------------------------
	always @(posedge core_clk) if (!srst) begin
		if (awvalid && awready) begin
			check(awaddr, exp_addr.size() ? exp_addr.pop_front() : 'x, "addr");
			check({awlen, awsize, awburst}, {AXI_LEN, AXI_SIZE, AXI_INCR}, "len");
		end
		if (wvalid && wready) begin
			check(wdata, exp_beat.size() ? exp_beat.pop_front() : 'x, "data");
			check(wlast, beat_n == 15, "last");
			check(wstrb, {(BEAT_W/8){1'b1}}, "strb");
			beat_n <= (beat_n + 1) % BURST_BEATS;
		end
		if (bvalid)
			check(bready, 1'b1, "bready");
	end
	// ------------------------------------------------
	// one frame: model, drive, wait, status, clear
	// ------------------------------------------------
	task automatic send_frame(bit is_data, int n);
		logic [31:0] q[$];
		logic [31:0] w[$];
		logic [7:0] ty;
		logic [31:0] base;
		int k;
		int bursts;
		ty = is_data ? FIS_TYPE_DATA : (($urandom % 2) ? 8'h34 : 8'h27);
		q.push_back(($urandom & 32'hFFFF_FF00) | {24'h00_0000, ty});
		for (k = 1; k < (is_data ? n + 1 : n); k++)
			q.push_back($urandom);
		w = q;
		if (is_data)
			w.delete(0);
		while (w.size() % BURST_WORDS != 0)
			w.push_back(32'h0000_0000);
		for (k = 0; k < w.size(); k += WORDS_PER_BEAT)
			exp_beat.push_back({w[k+7], w[k+6], w[k+5], w[k+4],
				w[k+3], w[k+2], w[k+1], w[k]});
		base = is_data ? disk_image_region_base : other_frame_region_base;
		bursts = w.size() / BURST_WORDS;
		for (k = 0; k < bursts; k++)
			exp_addr.push_back(base + k * BURST_BYTES);
		start_transfer <= 1'b1;
		@(posedge core_clk);
		start_transfer <= 1'b0;
		@(negedge core_clk);
		check(status_word[CNT_W-1:0], CNT_RESET, "count cleared");
		@(posedge core_clk);
		for (k = 0; k < q.size(); k++) begin
			rx_data  <= q[k];
			rx_valid <= 1'b1;
			rx_sof   <= (k == 0);
			rx_eof   <= (k == q.size() - 1);
			do @(negedge core_clk); while (rx_ready !== 1'b1);
			@(posedge core_clk);
			if ($urandom % 4 == 0 || k == q.size() - 1) begin
				rx_valid <= 1'b0;
				rx_data  <= ~q[k];
				@(posedge core_clk);
			end
		end
		k = 0;
		do begin
			@(negedge core_clk);
			k++;
			if (frame_irq !== 1'b1)
				check(rx_ready, 1'b0, "ready while busy");
		end while (frame_irq !== 1'b1 && k < 3000);
		check(frame_irq, 1'b1, "irq");
		check(status_word[STAT_TYPE_BIT], !is_data, "type");
		check(status_word[CNT_W-1:0], n, "count");
		check(rx_destination_select, !is_data, "select");
		check(exp_beat.size() + exp_addr.size(), 0, "all written");
		@(posedge core_clk);
		int_clear_wr   <= 1'b1;
		int_clear_data <= 32'h2000_0000;
		@(posedge core_clk);
		int_clear_data <= 32'h4000_0000;
		@(posedge core_clk);
		int_clear_wr   <= 1'b0;
		@(negedge core_clk);
		check(frame_irq, 1'b0, "irq cleared");
		check(status_word[STAT_TYPE_BIT], 1'b0, "type cleared");
	endtask
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		int sizes[4];
		sizes = '{130, 5, 128, 129};
		fails = 0;
		cmp_count = 0;
		cycles = 0;
		beat_n = 0;
		srst = 1'b1;
		{rx_valid, rx_sof, rx_eof, start_transfer, int_clear_wr} = 5'h00;
		rx_data = 32'h0000_0000;
		int_clear_data = 32'h0000_0000;
		void'($urandom(32'h3427));
		repeat (10) @(posedge core_clk);
		srst <= 1'b0;
		@(negedge core_clk);
		check({frame_irq, status_word, awvalid, wvalid}, 0, "reset");
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			// bases kept on burst boundaries by software
			disk_image_region_base  <= $urandom & 32'hFFFF_FE00;
			other_frame_region_base <= $urandom & 32'hFFFF_FE00;
			@(posedge core_clk);
			send_frame(i % 2 == 0, sizes[i]);
		end
		final_report();
	end
endmodule // test_rx_frame_writer
`default_nettype wire
